/* tb/aci_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Comparator cells and event source
// ---------------------------------------------------------------
module aci_partner
  import aci_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               startComparison,
  input  wire logic [NUM_CH-1:0]  cmpSet,
  input  wire logic [NUM_WIN-1:0] winSet,
  input  wire logic               fireEvent,
  output logic      [NUM_CH-1:0]  comparatorOutput,
  output logic      [NUM_CH-1:0]  outputValid,
  output logic      [NUM_WIN-1:0] windowInside,
  output logic                    peripheralEvent,
  output logic                    comparisonDone
);
  // Slow on purpose, so start bits can be seen before they clear
  logic [3:0] busy = 4'h0;
  always_ff @(posedge mclk) begin
    comparatorOutput <= cmpSet;
    windowInside     <= winSet;
    outputValid      <= 8'hFF;
    peripheralEvent  <= fireEvent;
    comparisonDone   <= (busy == 4'h1);
    if (startComparison) begin
      busy <= 4'hC;
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
    end
  end
endmodule : aci_partner
`default_nettype wire

/* tb/comparator_ctrl_status_irq_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module comparator_ctrl_status_irq_tb
  import aci_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [7:0]  channelEnable = 8'h00;
  logic [7:0]  cmpSet = 8'h00;
  logic [7:0]  comparatorIrqEvent = 8'h00;
  logic [3:0]  winSet = 4'h0;
  logic [3:0]  windowModeEnable = 4'h0;
  logic [3:0]  windowIrqEvent = 4'h0;
  logic        fireEvent = 1'b0;
  logic [31:0] readdata;
  logic [31:0] rnd = 32'h0000_004C;
  logic [7:0]  comparatorOutput, outputValid, channelActive, channelResult;
  logic [3:0]  windowInside;
  logic        waitrequest, peripheralEvent, comparisonDone, interfaceEnable;
  logic        startComparison, startFromEvent, irqRequest;
  int          fails = 0;
  int          nTests = 0;
  int          cyc = 0;
  logic [7:0]  nSwStarts = 8'h00;
  logic [7:0]  nEvStarts = 8'h00;
  localparam logic [7:0] OFFS [6] = '{8'h00, 8'h04, 8'h18, 8'h1C, 8'h24, 8'h40};

  aci_ctrl_status dut (.mclk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .channelEnable, .comparatorOutput, .outputValid, .comparatorIrqEvent, .windowInside,
    .windowModeEnable, .windowIrqEvent, .peripheralEvent, .comparisonDone, .interfaceEnable,
    .channelActive, .channelResult, .startComparison, .startFromEvent, .irqRequest);
  aci_partner partner (.mclk, .startComparison(startComparison | startFromEvent), .cmpSet, .winSet,
    .fireEvent, .comparatorOutput, .outputValid, .windowInside, .peripheralEvent, .comparisonDone);

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (!rst) begin
      nSwStarts <= nSwStarts + {7'h00, startComparison};
      nEvStarts <= nEvStarts + {7'h00, startFromEvent};
    end
    if (cyc > 4000) begin
      fails++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] expStatus(input logic [7:0] res, input logic [7:0] rdy, input logic [3:0] w);
    logic [31:0] s;
    s = {4'h0, w, 24'h00_0000};
    for (int i = 0; i < 8; i++) begin
      s[2*i] = res[i];
      s[2*i+1] = rdy[i];
    end
    return s;
  endfunction : expStatus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Extra edge after release keeps two requests from sharing a time step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] m, x, ctl;
    m = 32'h0000_0000;
    ctl = 32'h0000_0301;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) rd(OFFS[i], RESET_VALUE);
    channelEnable <= 8'hFF;
    windowModeEnable <= 4'hF;
    wr(OFF_CONTROL, ctl);
    chk({23'h0, interfaceEnable, channelActive}, 32'h0000_0100);
    // Active STARTUP_CYCLES+1 cycles after the enable write lands
    repeat (3) @(posedge mclk);
    chk({24'h0, channelActive}, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    chk({24'h0, channelActive}, 32'h0000_00FF);
    rd(OFF_IRQ_PENDING, 32'h0000_AAAA);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(lfsr(rnd));
      m = m | (rnd & IRQ_VALID);
      wr(OFF_IRQ_ENABLE_SET, rnd);
      rd(OFF_IRQ_MASK, m);
      chk({31'h0, irqRequest}, {31'h0, |(m & 32'h0000_AAAA)});
      rnd = lfsr(rnd);
      m = m & ~rnd;
      wr(OFF_IRQ_ENABLE_CLEAR, rnd);
      rd(OFF_IRQ_MASK, m);
    end
    wr(OFF_IRQ_MASK, 32'hFFFF_FFFF);
    rd(OFF_IRQ_MASK, m);
    wr(OFF_IRQ_ENABLE_SET, IRQ_VALID);
    chk({31'h0, irqRequest}, 32'h0000_0001);
    wr(OFF_IRQ_CLEAR, 32'h0000_AAAA);
    rd(OFF_IRQ_PENDING, 32'h0000_0000);
    chk({31'h0, irqRequest}, 32'h0000_0000);
    // Pair 1 out of window mode: its event must not pend
    windowModeEnable <= 4'hD;
    comparatorIrqEvent <= 8'h04;
    windowIrqEvent <= 4'h6;
    @(posedge mclk);
    comparatorIrqEvent <= 8'h00;
    windowIrqEvent <= 4'h0;
    @(posedge mclk);
    rd(OFF_IRQ_PENDING, 32'h0400_0010);
    wr(OFF_IRQ_CLEAR, 32'h0000_0000);
    rd(OFF_IRQ_PENDING, 32'h0400_0010);
    wr(OFF_IRQ_CLEAR, 32'h0400_0000);
    rd(OFF_IRQ_PENDING, 32'h0000_0010);
    wr(OFF_IRQ_ENABLE_CLEAR, IRQ_VALID);
    chk({31'h0, irqRequest}, 32'h0000_0000);
    channelEnable <= 8'h7F;
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(lfsr(rnd));
      cmpSet <= rnd[7:0];
      winSet <= rnd[11:8];
      repeat (5) @(posedge mclk);
      rd(OFF_STATUS, expStatus(rnd[7:0], 8'h7F, rnd[11:8]));
      chk({24'h0, channelResult}, {24'h0, rnd[7:0]});
    end
    rnd = lfsr(rnd);
    channelEnable <= 8'hFF;
    wr(OFF_TEST, {24'h0, ~rnd[7:0]});
    wr(OFF_CONTROL, ctl | 32'h0000_0080);
    repeat (2) @(posedge mclk);
    rd(OFF_STATUS, expStatus(~rnd[7:0], 8'hFF, winSet));
    wr(OFF_CONTROL, ctl);
    for (int b = 4; b < 6; b++) begin
      wr(OFF_CONTROL, ctl | (32'h0000_0001 << b));
      rd(OFF_CONTROL, ctl | (32'h0000_0001 << b));
      repeat (16) @(posedge mclk);
      rd(OFF_CONTROL, ctl);
    end
    for (int b = 0; b < 2; b++) begin
      x = ctl | ((b == 1) ? 32'h0000_0002 : 32'h0000_0000);
      wr(OFF_CONTROL, x);
      fireEvent <= 1'b1;
      @(posedge mclk);
      fireEvent <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(OFF_CONTROL, x | ((b == 1) ? 32'h0000_0020 : 32'h0000_0000));
      repeat (16) @(posedge mclk);
      rd(OFF_CONTROL, x);
    end
    chk({16'h0000, nSwStarts, nEvStarts}, 32'h0000_0102);
    wr(OFF_CONTROL, 32'h0000_0000);
    chk({23'h0, interfaceEnable, channelActive}, 32'h0000_0000);
    conclude();
  end
endmodule : comparator_ctrl_status_irq_tb
`default_nettype wire

/* verilog/aci_ctrl_status.sv */
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module aci_ctrl_status
  import aci_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  input  wire logic [NUM_CH-1:0]    channelEnable,
  input  wire logic [NUM_CH-1:0]    comparatorOutput,
  input  wire logic [NUM_CH-1:0]    outputValid,
  input  wire logic [NUM_CH-1:0]    comparatorIrqEvent,
  input  wire logic [NUM_WIN-1:0]   windowInside,
  input  wire logic [NUM_WIN-1:0]   windowModeEnable,
  input  wire logic [NUM_WIN-1:0]   windowIrqEvent,
  input  wire logic                 peripheralEvent,
  input  wire logic                 comparisonDone,
  output logic                      interfaceEnable,
  output logic [NUM_CH-1:0]         channelActive,
  output logic [NUM_CH-1:0]         channelResult,
  output logic                      startComparison,
  output logic                      startFromEvent,
  output logic                      irqRequest
);
  // ---------------------------------------------------------------
  // Input synchronisers (analog side is asynchronous)
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0]  cmpMeta, cmpSync, vldMeta, vldSync;
  logic [NUM_WIN-1:0] winMeta, winSync;
  logic               evMeta, evSync, evSyncDly;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmpMeta   <= '0;
      cmpSync   <= '0;
      vldMeta   <= '0;
      vldSync   <= '0;
      winMeta   <= '0;
      winSync   <= '0;
      evMeta    <= 1'b0;
      evSync    <= 1'b0;
      evSyncDly <= 1'b0;
    end else begin
      cmpMeta   <= comparatorOutput;
      cmpSync   <= cmpMeta;
      vldMeta   <= outputValid;
      vldSync   <= vldMeta;
      winMeta   <= windowInside;
      winSync   <= winMeta;
      evMeta    <= peripheralEvent;
      evSync    <= evMeta;
      evSyncDly <= evSync;
    end
  end

  // ---------------------------------------------------------------
  // Bus slave: one wait state on every access
  // ---------------------------------------------------------------
  logic        busAck;
  logic [31:0] control, testValue, irqMask, irqPending, statusWord;

  assign waitrequest = (read | write) & ~busAck;

  always_ff @(posedge mclk) begin
    if (rst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (read | write) & ~busAck;
    end
  end

  function automatic logic wrHit(input logic [7:0] off);
    wrHit = write & busAck & (address == off);
  endfunction : wrHit

  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata <= RESET_VALUE;
    end else if (read & ~busAck) begin
      unique case (address)
        OFF_CONTROL:     readdata <= control;
        OFF_STATUS:      readdata <= statusWord;
        OFF_IRQ_MASK:    readdata <= irqMask;
        OFF_IRQ_PENDING: readdata <= irqPending;
        OFF_TEST:        readdata <= testValue;
        default:         readdata <= BAD_READ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic evAccepted;
  assign interfaceEnable = control[CTL_ENABLE];
  assign evAccepted = evSync & ~evSyncDly & control[CTL_EVENT_EN]
                      & control[CTL_ENABLE];

  always_ff @(posedge mclk) begin
    if (rst) begin
      control <= RESET_VALUE;
    end else begin
      if (wrHit(OFF_CONTROL)) begin
        control[CTL_ENABLE]   <= writedata[CTL_ENABLE];
        control[CTL_EVENT_EN] <= writedata[CTL_EVENT_EN];
        control[CTL_TEST_OVR] <= writedata[CTL_TEST_OVR];
        control[CTL_SUT_LSB +: SUT_WIDTH] <= writedata[CTL_SUT_LSB +: SUT_WIDTH];
      end
      // Start set beats completion clear in the same cycle
      if ((wrHit(OFF_CONTROL) & writedata[CTL_SW_START]))
        control[CTL_SW_START] <= 1'b1;
      else if (comparisonDone)
        control[CTL_SW_START] <= 1'b0;
      if ((wrHit(OFF_CONTROL) & writedata[CTL_EV_START]) | evAccepted)
        control[CTL_EV_START] <= 1'b1;
      else if (comparisonDone)
        control[CTL_EV_START] <= 1'b0;
      if (~control[CTL_ENABLE]) begin
        control[CTL_SW_START] <= 1'b0;
        control[CTL_EV_START] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      testValue <= RESET_VALUE;
    end else if (wrHit(OFF_TEST)) begin
      testValue <= {24'h00_0000, writedata[NUM_CH-1:0]};
    end
  end

  // Pulse on the rising edge of each start bit
  logic swStartDly, evStartDly;
  always_ff @(posedge mclk) begin
    if (rst) begin
      swStartDly <= 1'b0;
      evStartDly <= 1'b0;
    end else begin
      swStartDly <= control[CTL_SW_START];
      evStartDly <= control[CTL_EV_START];
    end
  end
  assign startComparison = control[CTL_SW_START] & ~swStartDly;
  assign startFromEvent  = control[CTL_EV_START] & ~evStartDly;

  // ---------------------------------------------------------------
  // Per-channel startup counters and status
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] startupOver, startupPulse, effOutput;
  assign effOutput = control[CTL_TEST_OVR] ? testValue[NUM_CH-1:0] : cmpSync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [SUT_WIDTH-1:0] sutCount;
      logic                 chOn;
      assign chOn = channelEnable[gi] & control[CTL_ENABLE];
      always_ff @(posedge mclk) begin
        if (rst) begin
          sutCount           <= '0;
          startupOver[gi]    <= 1'b0;
          startupPulse[gi]   <= 1'b0;
        end else begin
          startupPulse[gi] <= 1'b0;
          if (~chOn) begin
            sutCount        <= '0;
            startupOver[gi] <= 1'b0;
          end else if (~startupOver[gi]) begin
            if (sutCount >= control[CTL_SUT_LSB +: SUT_WIDTH]) begin
              startupOver[gi]  <= 1'b1;
              startupPulse[gi] <= 1'b1;
            end else begin
              sutCount <= sutCount + 1'b1;
            end
          end
        end
      end
      assign channelActive[gi] = chOn & startupOver[gi];
      always_ff @(posedge mclk) begin
        if (rst) begin
          statusWord[2*gi]   <= 1'b0;
          statusWord[2*gi+1] <= 1'b0;
          channelResult[gi]  <= 1'b0;
        end else begin
          statusWord[2*gi]   <= effOutput[gi];
          statusWord[2*gi+1] <= (vldSync[gi] | control[CTL_TEST_OVR])
                                & chOn & startupOver[gi];
          channelResult[gi]  <= effOutput[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      statusWord[31:16] <= '0;
    end else begin
      statusWord[23:16]  <= '0;
      statusWord[31:28]  <= '0;
      statusWord[WIN_LSB +: NUM_WIN] <= winSync & {NUM_WIN{control[CTL_ENABLE]}};
    end
  end

  // ---------------------------------------------------------------
  // Interrupt mask, pending and request
  // ---------------------------------------------------------------
  logic [31:0] irqSet;
  always_comb begin
    irqSet = '0;
    for (int n = 0; n < NUM_CH; n++) begin
      irqSet[2*n]   = comparatorIrqEvent[n] & control[CTL_ENABLE];
      irqSet[2*n+1] = startupPulse[n];
    end
    irqSet[WIN_LSB +: NUM_WIN] = windowIrqEvent & windowModeEnable
                                 & {NUM_WIN{control[CTL_ENABLE]}};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqMask <= RESET_VALUE;
    end else if (wrHit(OFF_IRQ_ENABLE_SET)) begin
      irqMask <= irqMask | (writedata & IRQ_VALID);
    end else if (wrHit(OFF_IRQ_ENABLE_CLEAR)) begin
      irqMask <= irqMask & ~(writedata & IRQ_VALID);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqPending <= RESET_VALUE;
    end else begin
      // New events win over a simultaneous clear
      irqPending <= (irqPending & ~(wrHit(OFF_IRQ_CLEAR) ? writedata : 32'h0000_0000))
                    | irqSet;
    end
  end

  assign irqRequest = |(irqPending & irqMask);

  // ---------------------------------------------------------------
  // Write strobes seen by the checks
  // ---------------------------------------------------------------
  // Properties sample these; a function call would read live values
  logic wrCtl, wrSet, wrClr, wrIcr;
  always_comb begin
    wrCtl = wrHit(OFF_CONTROL);
    wrSet = wrHit(OFF_IRQ_ENABLE_SET);
    wrClr = wrHit(OFF_IRQ_ENABLE_CLEAR);
    wrIcr = wrHit(OFF_IRQ_CLEAR);
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_mask_set: assert property (@(posedge mclk) disable iff (rst)
    wrSet |=> ((irqMask & $past(writedata) & IRQ_VALID) == ($past(writedata) & IRQ_VALID)))
    else $error("mask not set by enable write");
  chk_mask_clear: assert property (@(posedge mclk) disable iff (rst)
    wrClr |=> ((irqMask & $past(writedata)) == 32'h0000_0000))
    else $error("mask not cleared by disable write");
  chk_mask_stable: assert property (@(posedge mclk) disable iff (rst)
    !wrSet && !wrClr |=> $stable(irqMask))
    else $error("mask changed without write");
  chk_irq_out: assert property (@(posedge mclk) disable iff (rst)
    irqRequest == ((irqPending & irqMask) != 32'h0000_0000))
    else $error("irq output mismatch");
  chk_pend_hold: assert property (@(posedge mclk) disable iff (rst)
    irqPending[WIN_LSB] && !(wrIcr && writedata[WIN_LSB]) |=> irqPending[WIN_LSB])
    else $error("window pending lost without clear");
  chk_pend_set: assert property (@(posedge mclk) disable iff (rst)
    irqSet[WIN_LSB] |=> irqPending[WIN_LSB])
    else $error("window pending not set");
  chk_startup_irq: assert property (@(posedge mclk) disable iff (rst)
    startupPulse[0] |=> irqPending[1])
    else $error("startup pending not set");
  chk_ready_needs: assert property (@(posedge mclk) disable iff (rst)
    statusWord[1] |-> $past(startupOver[0]) && $past(g_ch[0].chOn))
    else $error("ready without startup");
  chk_sw_start: assert property (@(posedge mclk) disable iff (rst)
    wrCtl && writedata[CTL_SW_START] && control[CTL_ENABLE] |=> control[CTL_SW_START])
    else $error("software start not set");
  chk_ev_block: assert property (@(posedge mclk) disable iff (rst)
    !control[CTL_EV_START] && !control[CTL_EVENT_EN] && !wrCtl |=> !control[CTL_EV_START])
    else $error("event start while disabled");
  chk_disable_all: assert property (@(posedge mclk) disable iff (rst)
    !control[CTL_ENABLE] |-> ##1 (channelActive == '0))
    else $error("channel active while disabled");
  chk_test_ovr: assert property (@(posedge mclk) disable iff (rst)
    control[CTL_TEST_OVR] && $stable(control[CTL_TEST_OVR]) |=> channelResult == $past(testValue[NUM_CH-1:0]))
    else $error("test override ignored");

  // ---------------------------------------------------------------
  // Checks: start bits, status and clearing
  // ---------------------------------------------------------------
  chk_ev_set: assert property (@(posedge mclk) disable iff (rst)
    evAccepted |=> control[CTL_EV_START])
    else $error("event start not set by event");
  chk_ev_done: assert property (@(posedge mclk) disable iff (rst)
    control[CTL_EV_START] && comparisonDone && !evAccepted
    && !(wrCtl && writedata[CTL_EV_START]) |=> !control[CTL_EV_START])
    else $error("event start not cleared when done");
  chk_sw_done: assert property (@(posedge mclk) disable iff (rst)
    control[CTL_SW_START] && comparisonDone && !(wrCtl && writedata[CTL_SW_START]) |=> !control[CTL_SW_START])
    else $error("software start not cleared when done");
  chk_zero_start: assert property (@(posedge mclk) disable iff (rst)
    wrCtl && !writedata[CTL_SW_START] && !control[CTL_SW_START] |=> !control[CTL_SW_START])
    else $error("zero write set software start");
  chk_ev_zero: assert property (@(posedge mclk) disable iff (rst)
    wrCtl && !writedata[CTL_EV_START] && !evAccepted && !control[CTL_EV_START] |=> !control[CTL_EV_START])
    else $error("zero write set event start");
  chk_sw_pulse: assert property (@(posedge mclk) disable iff (rst)
    startComparison |=> !startComparison)
    else $error("software start pulse too long");
  chk_ev_pulse: assert property (@(posedge mclk) disable iff (rst)
    startFromEvent |=> !startFromEvent)
    else $error("event start pulse too long");
  chk_off_events: assert property (@(posedge mclk) disable iff (rst)
    !control[CTL_ENABLE] |-> ((irqSet & 32'h0F00_5555) == 32'h0000_0000))
    else $error("interrupt event while disabled");
  chk_win_status: assert property (@(posedge mclk) disable iff (rst)
    control[CTL_ENABLE] |=> (statusWord[WIN_LSB +: NUM_WIN] == $past(winSync)))
    else $error("window status does not follow input");
  chk_result_bit: assert property (@(posedge mclk) disable iff (rst)
    !control[CTL_TEST_OVR] |=> (statusWord[0] == $past(cmpSync[0])))
    else $error("result bit does not follow comparator");
  chk_ready_off: assert property (@(posedge mclk) disable iff (rst)
    !g_ch[0].chOn |=> !statusWord[1])
    else $error("ready while channel off");
  chk_startup_wait: assert property (@(posedge mclk) disable iff (rst)
    g_ch[0].chOn && !startupOver[0] && (g_ch[0].sutCount < control[CTL_SUT_LSB +: SUT_WIDTH]) |=> !startupOver[0])
    else $error("startup ended early");
  chk_irq_withdraw: assert property (@(posedge mclk) disable iff (rst)
    wrIcr && ((irqPending & ~writedata) == 32'h0000_0000) && (irqSet == 32'h0000_0000) |=> !irqRequest)
    else $error("request not withdrawn by clear");
  chk_clear_zero: assert property (@(posedge mclk) disable iff (rst)
    wrIcr && (writedata == 32'h0000_0000) |=> ((irqPending & $past(irqPending)) == $past(irqPending)))
    else $error("zero clear write changed pending");
  chk_pend_clear: assert property (@(posedge mclk) disable iff (rst)
    wrIcr && writedata[1] && !irqSet[1] |=> !irqPending[1])
    else $error("pending bit not cleared");
  chk_mask_valid: assert property (@(posedge mclk) disable iff (rst)
    (irqMask & ~IRQ_VALID) == 32'h0000_0000)
    else $error("reserved mask bit set");

  cov_event_start: cover property (@(posedge mclk) disable iff (rst) evAccepted ##1 control[CTL_EV_START]);
  cov_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irqRequest));
  cov_startup: cover property (@(posedge mclk) disable iff (rst) $rose(channelActive[0]));
  cov_window_irq: cover property (@(posedge mclk) disable iff (rst) irqSet[WIN_LSB+2] ##1 irqPending[WIN_LSB+2]);
  cov_test_ovr: cover property (@(posedge mclk) disable iff (rst) $rose(control[CTL_TEST_OVR]));
endmodule : aci_ctrl_status
`default_nettype wire

/* verilog/aci_pkg.sv */
package aci_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL          = 8'h00;
  localparam logic [7:0] OFF_STATUS           = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET   = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK         = 8'h18;
  localparam logic [7:0] OFF_IRQ_PENDING      = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CLEAR        = 8'h20;
  localparam logic [7:0] OFF_TEST             = 8'h24;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTL_ENABLE      = 0;
  localparam int CTL_EVENT_EN    = 1;
  localparam int CTL_SW_START    = 4;
  localparam int CTL_EV_START    = 5;
  localparam int CTL_TEST_OVR    = 7;
  localparam int CTL_SUT_LSB     = 8;
  localparam int SUT_WIDTH       = 10;
  localparam int NUM_CH          = 8;
  localparam int NUM_WIN         = 4;
  localparam int WIN_LSB         = 24;
  localparam logic [31:0] CONTROL_WMASK = 32'h0003_FF83;
  localparam logic [31:0] IRQ_VALID     = 32'h0F00_FFFF;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  localparam logic [31:0] BAD_READ      = 32'h0000_0000;
endpackage : aci_pkg
